// ### hw/tcc_timer.sv
// 16-bit timer/counter core with compare, capture and output control
`timescale 1ns/100ps
`include "tcc_map.svh"

// Function
// - count up once per selected count clock
// - codes 1-9 divide clock, 15 external edges
// - prescale select resets to 11h
// - enabling clears on first tick, then counts
// - disabling zeroes count, stops capture, matches
// - re-enabling while enabled keeps counting
// - wrap at maximum, set overflow, keep counting
// - overflow flag cleared only by software
// - reset zeroes count; word-only reads
// - timer control low nibble used, resets zero
// - compare match raises interrupt and output signal
// - compare registers accessed as words only
// - valid edge captures count, reset zero
// - valid edge gives interrupt, capture, count clock
// - clear-on-match bit and output mode bits
// - capture/compare control resets to 10h
// - match inverts output; PWM on both pins, PPG on pin a only
// - disabled output drives fixed level
// - one-shot trigger bits write-only, read zero
// - software sets one-shot, match ends it
// - matched count held until next tick, then cleared
module tcc_timer #(
  parameter int CNT_W = 16,
  parameter int PS_W  = 11
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire tcc_pkg::tcc_sfr_req_t sfr_req,
  output logic [15:0]              sfr_rdata,
  input  wire logic                external_edge_input,
  input  wire logic [1:0]          edge_mode_register,
  output tcc_pkg::tcc_events_t     events,
  output logic                     timer_output_a,
  output logic                     timer_output_b
);
  import tcc_pkg::*;

  // Register state
  logic [7:0]       prescale_select_r, timer_control_r, capture_compare_control_r;
  logic [7:0]       output_control_r, oneshot_control_r;
  logic [CNT_W-1:0] count_value_r, compare_a_r, compare_b_r, capture_value_r;
  logic [15:0]      rdata_r;
  tcc_cnt_state_t   state_r, state_nxt;
  logic [CNT_W-1:0] count_nxt;
  logic             clr_pend_r, match_a_d_r, match_b_d_r;
  logic             level_a_r, level_b_r, pin_a_r, pin_b_r;
  tcc_events_t      events_r;

  // Access decode wires
  logic       byte_wr, word_wr, wr_prm, wr_tmc, wr_crc, wr_toc, wr_oneshot_control, wr_cmpa, wr_cmpb;
  logic [7:0] wbyte;

  // Counter control wires
  logic        count_tick, edge_pulse, count_enable_bit, ce_set, ce_clr, at_max;
  logic        match_a_now, match_b_now, match_a_rise, match_b_rise;
  logic        overflow_ev, overflow_flag_nxt, clear_on_match_b;
  logic [1:0]  out_mode_bits;
  tcc_omode_t  mode_a, mode_b;
  logic        level_a_nxt, level_b_nxt, pin_a_nxt, pin_b_nxt;
  logic [15:0] rdata_nxt;

  // Output mode decode for one pin
  function automatic tcc_omode_t out_mode(input logic is_b, input logic ent,
                                          input logic os, input logic [1:0] mod,
                                          input logic clr);
    if (!ent)
      return OM_FIXED;
    if (os)
      return OM_ONESHOT;
    if (is_b)
      return (mod == 2'b10 && !clr) ? OM_PWM : OM_TOGGLE;
    case (mod)
      2'b01:   return clr ? OM_TOGGLE : OM_PWM;
      2'b10:   return clr ? OM_TOGGLE : OM_PWM;
      2'b11:   return clr ? OM_PPG : OM_TOGGLE;
      default: return OM_TOGGLE;
    endcase
  endfunction

  // Internal level update for one pin
  function automatic logic next_level(input tcc_omode_t mode, input logic lvl,
                                      input logic own_match, input logic ovf,
                                      input logic other_match, input logic sw_set,
                                      input logic sw_rst, input logic running);
    case (mode)
      OM_TOGGLE:  return running & (lvl ^ own_match);
      OM_PWM:     return running & (ovf | (lvl & ~own_match));
      OM_PPG:     return running & (other_match | (lvl & ~own_match));
      OM_ONESHOT: return sw_set | (lvl & ~sw_rst & ~own_match);
      OM_FIXED:   return 1'b0;
      default:    return 1'b0;
    endcase
  endfunction

  // Count clock source and edge detector
  tcc_clock_sel #(
    .PS_W (PS_W)
  ) u_clock_sel (
    .clk        (clk),
    .rst        (rst),
    .clk_select (prescale_select_r[3:0]),
    .edge_mode  (edge_mode_register),
    .edge_in    (external_edge_input),
    .count_tick (count_tick),
    .edge_pulse (edge_pulse)
  );

  assign byte_wr = sfr_req.wr & ~sfr_req.word;
  assign word_wr = sfr_req.wr & sfr_req.word;
  assign wbyte   = sfr_req.wdata[7:0];
  assign wr_prm  = byte_wr && (sfr_req.addr == `TCC_ADDR_PRM);
  assign wr_tmc  = byte_wr && (sfr_req.addr == `TCC_ADDR_TMC);
  assign wr_crc  = byte_wr && (sfr_req.addr == `TCC_ADDR_CRC);
  assign wr_toc  = byte_wr && (sfr_req.addr == `TCC_ADDR_TOC);
  assign wr_oneshot_control = byte_wr && (sfr_req.addr == `TCC_ADDR_ONESHOT_CONTROL);
  assign wr_cmpa = word_wr && (sfr_req.addr == `TCC_ADDR_CMPA);
  assign wr_cmpb = word_wr && (sfr_req.addr == `TCC_ADDR_CMPB);

  // only a 0-to-1 change arms the counter
  assign count_enable_bit = timer_control_r[`TCC_TMC_CE];
  assign ce_set = wr_tmc & wbyte[`TCC_TMC_CE] & ~count_enable_bit;
  assign ce_clr = wr_tmc & ~wbyte[`TCC_TMC_CE];
  assign at_max = count_value_r == `TCC_CNT_MAX;

  assign clear_on_match_b = capture_compare_control_r[`TCC_CRC_CLR];
  assign out_mode_bits    = {capture_compare_control_r[`TCC_CRC_OUTPUT_MODE_HIGH],
                             capture_compare_control_r[`TCC_CRC_OUTPUT_MODE_LOW]};

  assign match_a_now  = (state_r == CNT_RUN) && (count_value_r == compare_a_r);
  assign match_b_now  = (state_r == CNT_RUN) && (count_value_r == compare_b_r);
  assign match_a_rise = match_a_now & ~match_a_d_r;
  assign match_b_rise = match_b_now & ~match_b_d_r;

  assign overflow_ev = (state_r == CNT_RUN) & count_tick & at_max & ~clr_pend_r;

  // hardware only sets; set wins over a software clear
  assign overflow_flag_nxt = overflow_ev |
                             (wr_tmc ? wbyte[`TCC_TMC_OVF] : timer_control_r[`TCC_TMC_OVF]);

  // Counter state and next count
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_value_r;
    case (state_r)
      CNT_STOP: begin
        if (ce_set)
          state_nxt = CNT_ARMED;
      end
      CNT_ARMED: begin
        if (count_tick) begin
          state_nxt = CNT_RUN;
          count_nxt = `TCC_RST_WORD;
        end
      end
      CNT_RUN: begin
        if (count_tick) begin
          // pending clear loads zero on this tick
          if (clr_pend_r)
            count_nxt = `TCC_RST_WORD;
          else if (at_max)
            count_nxt = `TCC_RST_WORD;
          else
            count_nxt = count_value_r + `TCC_CNT_ONE;
        end
      end
      default: begin
        state_nxt = CNT_STOP;
        count_nxt = `TCC_RST_WORD;
      end
    endcase
    if (ce_clr) begin
      state_nxt = CNT_STOP;
      count_nxt = `TCC_RST_WORD;
    end
  end

  // reset clears and stops the counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r       <= CNT_STOP;
      count_value_r <= `TCC_RST_WORD;
    end else begin
      state_r       <= state_nxt;
      count_value_r <= count_nxt;
    end
  end

  // hold the matched value until the next tick
  always_ff @(posedge clk) begin
    if (rst || ce_clr)
      clr_pend_r <= 1'b0;
    else if (match_b_rise && clear_on_match_b)
      clr_pend_r <= 1'b1;
    else if (count_tick)
      clr_pend_r <= 1'b0;
  end

  // Match history for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      match_a_d_r <= 1'b0;
      match_b_d_r <= 1'b0;
    end else begin
      match_a_d_r <= match_a_now;
      match_b_d_r <= match_b_now;
    end
  end

  // prescale select reset; timer control reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prescale_select_r <= `TCC_RST_PRM;
      timer_control_r   <= `TCC_RST_TMC;
    end else begin
      if (wr_prm)
        prescale_select_r <= wbyte;
      if (wr_tmc)
        timer_control_r <= wbyte;
      timer_control_r[`TCC_TMC_OVF] <= overflow_flag_nxt;
    end
  end

  // control reset with fixed bit held at one
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_compare_control_r <= `TCC_RST_CRC;
      output_control_r          <= `TCC_RST_TOC;
      oneshot_control_r         <= `TCC_RST_ONESHOT_CONTROL;
    end else begin
      if (wr_crc)
        capture_compare_control_r <= wbyte | `TCC_RST_CRC;
      if (wr_toc)
        output_control_r <= wbyte;
      if (wr_oneshot_control)
        oneshot_control_r <= wbyte & `TCC_ONESHOT_CONTROL_KEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compare_a_r <= `TCC_RST_WORD;
      compare_b_r <= `TCC_RST_WORD;
    end else begin
      if (wr_cmpa)
        compare_a_r <= sfr_req.wdata;
      if (wr_cmpb)
        compare_b_r <= sfr_req.wdata;
    end
  end

  // capture on valid edge while enabled
  always_ff @(posedge clk) begin
    if (rst)
      capture_value_r <= `TCC_RST_WORD;
    else if (edge_pulse && count_enable_bit)
      capture_value_r <= count_value_r;
  end

  assign mode_a = out_mode(1'b0, output_control_r[`TCC_TOC_ENT0],
                           oneshot_control_r[`TCC_ONESHOT_CONTROL_OS0], out_mode_bits,
                           clear_on_match_b);
  assign mode_b = out_mode(1'b1, output_control_r[`TCC_TOC_ENT1],
                           oneshot_control_r[`TCC_ONESHOT_CONTROL_OS1], out_mode_bits,
                           clear_on_match_b);

  // software set, match or reset trigger ends it
  assign level_a_nxt = next_level(mode_a, level_a_r, match_a_rise, overflow_ev,
                                  match_b_rise, wr_oneshot_control & wbyte[`TCC_ONESHOT_CONTROL_ST0],
                                  wr_oneshot_control & wbyte[`TCC_ONESHOT_CONTROL_RT0], count_enable_bit);
  assign level_b_nxt = next_level(mode_b, level_b_r, match_b_rise, overflow_ev,
                                  match_a_rise, wr_oneshot_control & wbyte[`TCC_ONESHOT_CONTROL_ST1],
                                  wr_oneshot_control & wbyte[`TCC_ONESHOT_CONTROL_RT1], count_enable_bit);

  // fixed level when disabled, else polarity from level bit
  assign pin_a_nxt = (mode_a == OM_FIXED) ? output_control_r[`TCC_TOC_ALV0] :
                     (mode_a == OM_PWM || mode_a == OM_PPG) ?
                     (level_a_nxt ^ output_control_r[`TCC_TOC_ALV0]) :
                     (level_a_nxt ^ ~output_control_r[`TCC_TOC_ALV0]);
  assign pin_b_nxt = (mode_b == OM_FIXED) ? output_control_r[`TCC_TOC_ALV1] :
                     (mode_b == OM_PWM) ?
                     (level_b_nxt ^ output_control_r[`TCC_TOC_ALV1]) :
                     (level_b_nxt ^ ~output_control_r[`TCC_TOC_ALV1]);

  // Output levels and pins
  always_ff @(posedge clk) begin
    if (rst) begin
      level_a_r <= 1'b0;
      level_b_r <= 1'b0;
      pin_a_r   <= 1'b0;
      pin_b_r   <= 1'b0;
    end else begin
      level_a_r <= level_a_nxt;
      level_b_r <= level_b_nxt;
      pin_a_r   <= pin_a_nxt;
      pin_b_r   <= pin_b_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      events_r <= '0;
    else begin
      events_r.match_a  <= match_a_rise;
      events_r.match_b  <= match_b_rise;
      events_r.overflow <= overflow_ev;
      events_r.ext_edge <= edge_pulse;
    end
  end

  // word-only reads of counter and capture; triggers read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (sfr_req.word) begin
      case (sfr_req.addr)
        `TCC_ADDR_CNT:  rdata_nxt = count_value_r;
        `TCC_ADDR_CMPA: rdata_nxt = compare_a_r;
        `TCC_ADDR_CMPB: rdata_nxt = compare_b_r;
        `TCC_ADDR_CAP:  rdata_nxt = capture_value_r;
        default:        rdata_nxt = 16'h0000;
      endcase
    end else begin
      case (sfr_req.addr)
        `TCC_ADDR_PRM:  rdata_nxt = {8'h00, prescale_select_r};
        `TCC_ADDR_TMC:  rdata_nxt = {8'h00, timer_control_r};
        `TCC_ADDR_CRC:  rdata_nxt = {8'h00, capture_compare_control_r};
        `TCC_ADDR_TOC:  rdata_nxt = {8'h00, output_control_r};
        `TCC_ADDR_ONESHOT_CONTROL: rdata_nxt = {8'h00, oneshot_control_r};
        default:        rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Read data register, updated on each read strobe
  always_ff @(posedge clk) begin
    if (rst)
      rdata_r <= 16'h0000;
    else if (sfr_req.rd)
      rdata_r <= rdata_nxt;
  end

  assign sfr_rdata      = rdata_r;
  assign events         = events_r;
  assign timer_output_a = pin_a_r;
  assign timer_output_b = pin_b_r;

endmodule

// ### hw/tcc_map.svh
// Register addresses, field positions, reset values and codes of the 16-bit timer
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Register addresses
`define TCC_ADDR_CRC      16'hff30
`define TCC_ADDR_PRM      16'hff5c
`define TCC_ADDR_CNT      16'hff50
`define TCC_ADDR_CMPA     16'hff52
`define TCC_ADDR_CMPB     16'hff54
`define TCC_ADDR_CAP      16'hff56
`define TCC_ADDR_TMC      16'hff5e
`define TCC_ADDR_TOC      16'hff60
`define TCC_ADDR_ONESHOT_CONTROL     16'hff62

// Reset values
`define TCC_RST_CRC       8'h10
`define TCC_RST_PRM       8'h11
`define TCC_RST_TMC       8'h00
`define TCC_RST_TOC       8'h00
`define TCC_RST_ONESHOT_CONTROL      8'h00
`define TCC_RST_WORD      16'h0000
`define TCC_CNT_MAX       16'hffff
`define TCC_CNT_ONE       16'h0001

// Timer control fields
`define TCC_TMC_OVF       0
`define TCC_TMC_CE        3

// Capture/compare control fields
`define TCC_CRC_CLR       3
`define TCC_CRC_FIX       4
`define TCC_CRC_OUTPUT_MODE_LOW      5
`define TCC_CRC_OUTPUT_MODE_HIGH      6

// Output control fields
`define TCC_TOC_ALV0      0
`define TCC_TOC_ENT0      1
`define TCC_TOC_ALV1      2
`define TCC_TOC_ENT1      3

// One-shot control fields
`define TCC_ONESHOT_CONTROL_ST0      0
`define TCC_ONESHOT_CONTROL_RT0      1
`define TCC_ONESHOT_CONTROL_ST1      2
`define TCC_ONESHOT_CONTROL_RT1      3
`define TCC_ONESHOT_CONTROL_OS0      4
`define TCC_ONESHOT_CONTROL_OS1      5
`define TCC_ONESHOT_CONTROL_KEEP     8'hf0

// Clock select codes
`define TCC_PS_DIV_MIN    4'h1
`define TCC_PS_DIV_MAX    4'h9
`define TCC_PS_EXT        4'hf
`define TCC_PS_SHIFT      4'h2

// Edge polarity codes
`define TCC_EDGE_FALL     2'h0
`define TCC_EDGE_RISE     2'h1
`define TCC_EDGE_BOTH     2'h2

`endif

// ### hw/tcc_pkg.sv
// Types shared by the timer core and its clock selector
package tcc_pkg;

  // CPU register access request
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        word;
    logic [15:0] wdata;
  } tcc_sfr_req_t;

  // Event pulses towards the interrupt controller
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic overflow;
    logic ext_edge;
  } tcc_events_t;

  // Counter states
  typedef enum logic [2:0] {
    CNT_STOP  = 3'b001,
    CNT_ARMED = 3'b010,
    CNT_RUN   = 3'b100
  } tcc_cnt_state_t;

  // Timer output modes
  typedef enum logic [4:0] {
    OM_FIXED   = 5'b00001,
    OM_TOGGLE  = 5'b00010,
    OM_PWM     = 5'b00100,
    OM_PPG     = 5'b01000,
    OM_ONESHOT = 5'b10000
  } tcc_omode_t;

endpackage

// ### hw/tcc_clock_sel.sv
// Prescaler, edge detector and count clock selector of the 16-bit timer
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_clock_sel #(
  parameter int PS_W = 11
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] clk_select,
  input  wire logic [1:0] edge_mode,
  input  wire logic       edge_in,
  output logic            count_tick,
  output logic            edge_pulse
);
  import tcc_pkg::*;

  logic [PS_W-1:0] ps_r;
  logic            sync1_r;
  logic            sync2_r;
  logic            prev_r;
  logic            rise;
  logic            fall;
  logic            div_tick;
  logic            div_code;

  // Tick when the low (code+2) prescaler bits are all ones
  function automatic logic div_hit(input logic [3:0] code, input logic [PS_W-1:0] cnt);
    logic [PS_W-1:0] mask;
    mask = {PS_W{1'b1}} >> (PS_W - int'(code + `TCC_PS_SHIFT));
    return (cnt & mask) == mask;
  endfunction

  // Free-running prescaler and input synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      ps_r    <= '0;
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      ps_r    <= ps_r + 1'b1;
      sync1_r <= edge_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  assign edge_pulse = (edge_mode == `TCC_EDGE_RISE) ? rise :
                      (edge_mode == `TCC_EDGE_FALL) ? fall :
                      (edge_mode == `TCC_EDGE_BOTH) ? (rise | fall) : 1'b0;

  assign div_code   = (clk_select >= `TCC_PS_DIV_MIN) && (clk_select <= `TCC_PS_DIV_MAX);
  assign div_tick   = div_code && div_hit(clk_select, ps_r);
  assign count_tick = div_tick | ((clk_select == `TCC_PS_EXT) & edge_pulse);

endmodule

// ### sim/tcc_timer_sva.sv
// Checker of the timer's register answers, event pulses and pin levels
`timescale 1ns/100ps
`include "tcc_map.svh"

module tcc_timer_sva #(
  parameter int CNT_W = 16,
  parameter int PS_W  = 11
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire tcc_pkg::tcc_sfr_req_t sfr_req,
  input wire logic [15:0]           sfr_rdata,
  input wire logic                  external_edge_input,
  input wire logic [1:0]            edge_mode_register,
  input wire tcc_pkg::tcc_events_t  events,
  input wire logic                  timer_output_a,
  input wire logic                  timer_output_b
);
  import tcc_pkg::*;
  // Address decode of the watched request
  wire logic mapped = sfr_req.addr inside {`TCC_ADDR_CRC, `TCC_ADDR_PRM, `TCC_ADDR_CNT,
    `TCC_ADDR_CMPA, `TCC_ADDR_CMPB, `TCC_ADDR_CAP, `TCC_ADDR_TMC, `TCC_ADDR_TOC, `TCC_ADDR_ONESHOT_CONTROL};
  wire logic rd_byte = sfr_req.rd && !sfr_req.word;
  wire logic wr_byte = sfr_req.wr && !sfr_req.word;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_unmapped: assert property (sfr_req.rd && !mapped |=> sfr_rdata == 16'h0000)
    else $error("unmapped read gave nonzero data");
  a_rdata_holds: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_cnt_byte_refused: assert property (
    rd_byte && sfr_req.addr == `TCC_ADDR_CNT |=> sfr_rdata == 16'h0000)
    else $error("byte read of count answered");
  a_crc_fixed_one: assert property (
    rd_byte && sfr_req.addr == `TCC_ADDR_CRC |=> sfr_rdata[4])
    else $error("fixed bit of capture/compare control read zero");
  a_trigger_bits_zero: assert property (
    rd_byte && sfr_req.addr == `TCC_ADDR_ONESHOT_CONTROL |=> sfr_rdata[3:0] == 4'h0)
    else $error("one-shot trigger bits read nonzero");
  a_ovf_pulse_single: assert property (events.overflow |=> !events.overflow)
    else $error("overflow pulse longer than one clock");
  a_match_a_single: assert property (events.match_a |=> !events.match_a)
    else $error("match a pulse longer than one clock");
  a_match_b_single: assert property (events.match_b |=> !events.match_b)
    else $error("match b pulse longer than one clock");
  a_edge_gives_event: assert property (
    $rose(external_edge_input) && edge_mode_register == 2'h1 |-> ##[2:6] events.ext_edge)
    else $error("rising edge gave no edge event");
  a_stop_quiets_match: assert property (
    wr_byte && sfr_req.addr == `TCC_ADDR_TMC && !sfr_req.wdata[3]
    |-> ##2 (!events.match_a && !events.match_b && !events.overflow)[*8])
    else $error("events after counter stop");
  a_fixed_pin_level: assert property (
    wr_byte && sfr_req.addr == `TCC_ADDR_TOC && !sfr_req.wdata[1]
    |-> ##2 timer_output_a == $past(sfr_req.wdata[0], 2))
    else $error("disabled pin a not at fixed level");
  c_edge_event: cover property (events.ext_edge);
endmodule

bind tcc_timer tcc_timer_sva #(.CNT_W(CNT_W), .PS_W(PS_W)) u_tcc_timer_sva (
  .clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .external_edge_input(external_edge_input), .edge_mode_register(edge_mode_register),
  .events(events), .timer_output_a(timer_output_a), .timer_output_b(timer_output_b));

// ### sim/tcc_pin_model.sv
// Pulse source on the edge input and load model of the two timer pins
`timescale 1ns/100ps

module tcc_pin_model (
  input  wire logic clk,
  output logic      edge_out,
  input  wire logic pin_a,
  input  wire logic pin_b,
  output int        n_chg_a,
  output int        n_chg_b
);
  logic last_a;
  logic last_b;

  // Idle low source, counters start empty
  initial begin
    edge_out = 1'b0;
    n_chg_a = 0;
    n_chg_b = 0;
  end

  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clk);
      edge_out <= 1'b1;
      repeat (6) @(posedge clk);
      edge_out <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask

  // Pin loads tally every level change
  always @(posedge clk) begin
    last_a <= pin_a;
    last_b <= pin_b;
    if (pin_a !== last_a) n_chg_a <= n_chg_a + 1;
    if (pin_b !== last_b) n_chg_b <= n_chg_b + 1;
  end
endmodule

// ### sim/tcc_timer_tb.sv
// Register-level testbench of the 16-bit timer
`timescale 1ns/100ps
`include "tcc_map.svh"
`define TB_CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("MISMATCH at %0t: %s", $time, msg); end end

module tcc_timer_tb;
  import tcc_pkg::*;
  logic         clk;
  logic         rst;
  tcc_sfr_req_t sfr_req;
  logic [15:0]  sfr_rdata;
  logic         edge_in;
  logic [1:0]   edge_mode;
  tcc_events_t  events;
  logic         pin_a;
  logic         pin_b;
  int           chg_a;
  int           chg_b;
  int           n_ma;
  int           n_mb;
  int           n_ext;
  int           miscompares;
  int           n_tests;
  int           s0;
  int           s1;
  int           s2;
  int           s3;
  logic [15:0]  d;
  logic [15:0]  c1;
  logic [15:0]  e;
  logic [15:0]  rv_addr [7] = '{`TCC_ADDR_CRC, `TCC_ADDR_PRM, `TCC_ADDR_TMC, `TCC_ADDR_TOC,
                              `TCC_ADDR_ONESHOT_CONTROL, `TCC_ADDR_CNT, `TCC_ADDR_CAP};
  logic [15:0]  rv_exp [7]  = '{16'h0010, 16'h0011, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0000};

  tcc_timer u_tcc_timer (.clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .external_edge_input(edge_in), .edge_mode_register(edge_mode), .events(events),
    .timer_output_a(pin_a), .timer_output_b(pin_b));
  tcc_pin_model u_tcc_pin_model (.clk(clk), .edge_out(edge_in), .pin_a(pin_a), .pin_b(pin_b),
    .n_chg_a(chg_a), .n_chg_b(chg_b));

  // 25 MHz clock
  always #20 clk = ~clk;

  // Event pulse tallies
  always @(posedge clk) begin
    if (events.match_a === 1'b1) n_ma <= n_ma + 1;
    if (events.match_b === 1'b1) n_mb <= n_mb + 1;
    if (events.ext_edge === 1'b1) n_ext <= n_ext + 1;
  end

  // One register write, taken at the second edge
  task automatic reg_wr(input logic [15:0] a, input logic w, input logic [15:0] v);
    @(posedge clk);
    sfr_req.addr <= a;
    sfr_req.word <= w;
    sfr_req.wdata <= v;
    sfr_req.wr <= 1'b1;
    @(posedge clk);
    sfr_req.wr <= 1'b0;
  endtask

  // One register read, data settled just after the taking edge
  task automatic reg_rd(input logic [15:0] a, input logic w, output logic [15:0] v);
    @(posedge clk);
    sfr_req.addr <= a;
    sfr_req.word <= w;
    sfr_req.rd <= 1'b1;
    @(posedge clk);
    sfr_req.rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    #4000000;
    miscompares++;
    $display("MISMATCH at %0t: run too long", $time);
    wrap_up();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    sfr_req = '0;
    edge_mode = 2'h1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      reg_rd(rv_addr[i], i > 4, d);
      `TB_CHK(d, rv_exp[i], "reset value")
    end
    reg_rd(16'hff40, 1'b0, d);
    `TB_CHK(d, 16'h0000, "unmapped read")
    reg_rd(`TCC_ADDR_CNT, 1'b0, d);
    `TB_CHK(d, 16'h0000, "byte read of count")
    $display("test resets done");
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0008);
    reg_rd(`TCC_ADDR_CNT, 1'b1, d);
    `TB_CHK(d, 16'h0000, "first tick loads zero")
    // count read only at divide 8 or slower with full-rate system clock
    for (int k = 0; k < 4; k++) begin
      reg_wr(`TCC_ADDR_PRM, 1'b0, 16'(k));
      reg_rd(`TCC_ADDR_CNT, 1'b1, c1);
      reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0008);
      repeat (124) @(posedge clk);
      reg_rd(`TCC_ADDR_CNT, 1'b1, d);
      e = (k == 0) ? 16'h0000 : 16'(128 >> (k + 2));
      `TB_CHK(d - c1, e, "ticks in 128 clocks")
    end
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0000);
    reg_rd(`TCC_ADDR_CNT, 1'b1, d);
    `TB_CHK(d, 16'h0000, "stop zeroes count")
    $display("test counting done");
    reg_wr(`TCC_ADDR_PRM, 1'b0, 16'h0001);
    reg_wr(`TCC_ADDR_CMPA, 1'b1, 16'h0002);
    reg_wr(`TCC_ADDR_CMPB, 1'b1, 16'h0004);
    reg_rd(`TCC_ADDR_CMPA, 1'b1, d);
    `TB_CHK(d, 16'h0002, "compare a readback")
    reg_wr(`TCC_ADDR_CRC, 1'b0, 16'h0008);
    reg_wr(`TCC_ADDR_TOC, 1'b0, 16'h000a);
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0008);
    repeat (100) @(posedge clk);
    s0 = n_ma;
    s1 = n_mb;
    s2 = chg_a;
    s3 = chg_b;
    repeat (160) @(posedge clk);
    `TB_CHK(n_ma - s0, 4, "match a pulses")
    `TB_CHK(n_mb - s1, 4, "match b pulses, five tick period")
    `TB_CHK(chg_a - s2, 4, "pin a toggles")
    `TB_CHK(chg_b - s3, 4, "pin b toggles")
    reg_rd(`TCC_ADDR_CNT, 1'b1, d);
    `TB_CHK(d <= 16'h0004, 1'b1, "count stays within compare b")
    reg_wr(`TCC_ADDR_CRC, 1'b0, 16'h0068);
    repeat (100) @(posedge clk);
    s2 = chg_a;
    repeat (160) @(posedge clk);
    `TB_CHK(chg_a - s2, 8, "pin a PPG edges")
    $display("test compare done");
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0000);
    reg_wr(`TCC_ADDR_CRC, 1'b0, 16'h0010);
    reg_wr(`TCC_ADDR_PRM, 1'b0, 16'h000f);
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0008);
    s0 = n_ext;
    u_tcc_pin_model.pulses(5);
    `TB_CHK(n_ext - s0, 5, "edge events")
    reg_rd(`TCC_ADDR_CNT, 1'b1, d);
    `TB_CHK(d, 16'h0004, "external edges counted")
    reg_rd(`TCC_ADDR_CAP, 1'b1, c1);
    `TB_CHK(c1 == 16'h0003 || c1 == 16'h0004, 1'b1, "capture of count")
    edge_mode <= 2'h2;
    u_tcc_pin_model.pulses(3);
    reg_rd(`TCC_ADDR_CNT, 1'b1, d);
    `TB_CHK(d, 16'h000a, "both edges counted")
    reg_rd(`TCC_ADDR_CAP, 1'b1, c1);
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0000);
    edge_mode <= 2'h1;
    u_tcc_pin_model.pulses(1);
    reg_rd(`TCC_ADDR_CAP, 1'b1, d);
    `TB_CHK(d, c1, "no capture while stopped")
    $display("test capture done");
    reg_wr(`TCC_ADDR_TOC, 1'b0, 16'h0005);
    repeat (3) @(posedge clk);
    `TB_CHK({pin_a, pin_b}, 2'b11, "fixed high levels")
    reg_wr(`TCC_ADDR_TOC, 1'b0, 16'h0000);
    repeat (3) @(posedge clk);
    `TB_CHK({pin_a, pin_b}, 2'b00, "fixed low levels")
    reg_wr(`TCC_ADDR_TOC, 1'b0, 16'h0002);
    reg_wr(`TCC_ADDR_ONESHOT_CONTROL, 1'b0, 16'h0010);
    repeat (3) @(posedge clk);
    `TB_CHK(pin_a, 1'b1, "one-shot idle level")
    reg_wr(`TCC_ADDR_ONESHOT_CONTROL, 1'b0, 16'h0011);
    repeat (3) @(posedge clk);
    `TB_CHK(pin_a, 1'b0, "one-shot set by software")
    reg_rd(`TCC_ADDR_ONESHOT_CONTROL, 1'b0, d);
    `TB_CHK(d, 16'h0010, "trigger bits read zero")
    reg_wr(`TCC_ADDR_ONESHOT_CONTROL, 1'b0, 16'h0012);
    repeat (3) @(posedge clk);
    `TB_CHK(pin_a, 1'b1, "one-shot reset by software")
    reg_wr(`TCC_ADDR_PRM, 1'b0, 16'h0001);
    reg_wr(`TCC_ADDR_CRC, 1'b0, 16'h0008);
    reg_wr(`TCC_ADDR_TMC, 1'b0, 16'h0008);
    reg_wr(`TCC_ADDR_ONESHOT_CONTROL, 1'b0, 16'h0011);
    repeat (100) @(posedge clk);
    `TB_CHK(pin_a, 1'b1, "one-shot ended by match")
    $display("test outputs done");
    wrap_up();
  end
endmodule
